// ### src/timer_output_control.sv
// Top of the timer output stage with Wishbone register slave
`timescale 1ns/1ns
`default_nettype none
module timer_output_control
  import tout_pkg::*;
#(
  parameter int CHANNELS = NCH,
  parameter int MASTER_CH = 0
)(
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [31:0]       wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Timer interrupt requests, one per channel, same clock
  input  wire logic [CHANNELS-1:0] timer_irq_i,
  // Timer output pins
  output logic      [CHANNELS-1:0] tout_o
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Value register is 16 bits, so no more channels fit in it
  if (CHANNELS < 1 || CHANNELS > 16) begin : g_bad_channels
    $error("timer_output_control: CHANNELS must be 1 to 16");
  end
  if (MASTER_CH < 0 || MASTER_CH >= CHANNELS) begin : g_bad_master
    $error("timer_output_control: MASTER_CH outside channel range");
  end

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  // Asserts at once, releases two edges later on a clean clock edge
  logic [1:0] rst_sync_ff;
  logic [1:0] nxt_rst_sync;
  logic       rst_n;

  always_comb begin
    nxt_rst_sync = {rst_sync_ff[0], 1'b1};
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= nxt_rst_sync;
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0]         delay_count_data_ch0_ff;
  logic [15:0]         nxt_delay;
  logic [15:0]         pulse_width_data_ch3_ff;
  logic [15:0]         nxt_pwidth;
  logic [15:0]         output_mode_select_ff;
  logic [15:0]         nxt_mode;
  logic [15:0]         output_polarity_select_ff;
  logic [15:0]         nxt_pol;
  logic [15:0]         output_enable_reg_ff;
  logic [15:0]         nxt_oe;
  logic                ack_ff;
  logic                nxt_ack;
  logic [31:0]         rdata_ff;
  logic [31:0]         nxt_rdata;
  logic [15:0]         output_value;
  logic [AW-1:0]       idx;
  logic                hit;
  logic                req;
  logic                wr;
  logic                rd;
  logic [CHANNELS-1:0] val;

  // ----------------------------------------
  // Address decode helpers
  // ----------------------------------------
  // Only sel[0] and sel[1] matter: registers live in the low half word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [15:0] r;
    r = old;
    if (s[0]) r[7:0] = d[7:0];
    if (s[1]) r[15:8] = d[15:8];
    return r;
  endfunction

  // Upper address bits must be zero for any register to answer
  function automatic logic in_map(input logic [31:0] a);
    return a[31:AW+2] == '0;
  endfunction

  // Registers are 16 bits; the upper half of a read is always zero
  function automatic logic [31:0] rd_word(input logic [15:0] r);
    return {16'h0000, r};
  endfunction

  assign idx = wb_adr_i[AW+1:2];
  assign hit = in_map(wb_adr_i);
  // Held ack blocks a second take of the same request
  assign req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr  = req & wb_we_i;
  assign rd  = req & ~wb_we_i;

  always_comb begin
    output_value = 16'h0000;
    output_value[CHANNELS-1:0] = val; // RULE5 RULE6
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Unmapped writes fall through untouched but are still acknowledged
  always_comb begin
    nxt_delay  = delay_count_data_ch0_ff;
    nxt_pwidth = pulse_width_data_ch3_ff;
    nxt_mode   = output_mode_select_ff;
    nxt_pol    = output_polarity_select_ff;
    nxt_oe     = output_enable_reg_ff;
    if (wr && hit) begin
      case (idx)
        IDX_DELAY:  nxt_delay  = merge(nxt_delay, wb_dat_i, wb_sel_i);
        IDX_PWIDTH: nxt_pwidth = merge(nxt_pwidth, wb_dat_i, wb_sel_i);
        IDX_MODE:   nxt_mode   = merge(nxt_mode, wb_dat_i, wb_sel_i);
        IDX_POL:    nxt_pol    = merge(nxt_pol, wb_dat_i, wb_sel_i);
        IDX_OE:     nxt_oe     = merge(nxt_oe, wb_dat_i, wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      delay_count_data_ch0_ff   <= RST_REG;
      pulse_width_data_ch3_ff   <= RST_REG;
      output_mode_select_ff     <= RST_REG;
      output_polarity_select_ff <= RST_REG;
      output_enable_reg_ff      <= RST_REG;
    end else begin
      delay_count_data_ch0_ff   <= nxt_delay;
      pulse_width_data_ch3_ff   <= nxt_pwidth;
      output_mode_select_ff     <= nxt_mode;
      output_polarity_select_ff <= nxt_pol;
      output_enable_reg_ff      <= nxt_oe;
    end
  end

  // ----------------------------------------
  // Bus answer
  // ----------------------------------------
  // Read data is registered, so every access answers after one wait
  always_comb begin
    nxt_ack   = req;
    nxt_rdata = rdata_ff;
    if (rd) begin
      if (!hit) begin
        nxt_rdata = RD_UNMAPPED;
      end else begin
        case (idx)
          IDX_DELAY:  nxt_rdata = rd_word(delay_count_data_ch0_ff);
          IDX_PWIDTH: nxt_rdata = rd_word(pulse_width_data_ch3_ff);
          IDX_MODE:   nxt_rdata = rd_word(output_mode_select_ff);
          IDX_POL:    nxt_rdata = rd_word(output_polarity_select_ff);
          IDX_VALUE:  nxt_rdata = rd_word(output_value);
          IDX_OE:     nxt_rdata = rd_word(output_enable_reg_ff);
          default:    nxt_rdata = RD_UNMAPPED;
        endcase
      end
    end
  end

  // Read data holds until the next read, not just for the ack cycle
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= RD_UNMAPPED;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

  // ----------------------------------------
  // Output channels
  // ----------------------------------------
  // Value write goes to all channels; enabled ones drop it themselves
  logic val_we;
  assign val_we = wr && hit && idx == IDX_VALUE && wb_sel_i[0];

  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    // Master channel itself can never be slave; its mode bit is ignored
    logic slave;
    assign slave = (c != MASTER_CH) && output_mode_select_ff[c];
    tout_chan u_chan (
      .clk_i        (clk_i),
      .rst_n_i      (rst_n),
      .slave_mode_i (slave),
      .pol_i        (output_polarity_select_ff[c]),
      .oe_i         (output_enable_reg_ff[c]),
      .master_irq_i (timer_irq_i[MASTER_CH]),
      .own_irq_i    (timer_irq_i[c]),
      .sw_we_i      (val_we),
      .sw_val_i     (wb_dat_i[c]),
      .val_o        (val[c])
    );
  end

  assign tout_o = val;
endmodule
`default_nettype wire

// ### src/tout_pkg.sv
// Package of constants for the timer output control block
// Function
// RULE1: Mode bit 1 makes channel slave; master irq sets output active.
// RULE2: In slave mode the channel's own irq returns output inactive.
// RULE3: Mode bit 0 makes channel master; own irq toggles output.
// RULE4: Polarity bit 0 gives active-high, 1 gives active-low output.
// RULE5: Output value bit 3 holds and shows the channel-3 pin level.
// RULE6: Output value bit 0 holds and shows the channel-0 pin level.
// RULE7: With output enable 1, timer drives value bit; writes ignored.
// RULE8: With output enable 0, events ignored; written value drives pin.
package tout_pkg;
  localparam int          NCH          = 4;
  localparam int          AW           = 3;
  // ----------------------------------------
  // Register word indices
  // ----------------------------------------
  localparam logic [AW-1:0] IDX_DELAY  = 3'h0;
  localparam logic [AW-1:0] IDX_PWIDTH = 3'h1;
  localparam logic [AW-1:0] IDX_MODE   = 3'h2;
  localparam logic [AW-1:0] IDX_POL    = 3'h3;
  localparam logic [AW-1:0] IDX_VALUE  = 3'h4;
  localparam logic [AW-1:0] IDX_OE     = 3'h5;
  localparam logic [15:0] RST_REG      = 16'h0000;
  localparam logic [31:0] RD_UNMAPPED  = 32'h0000_0000;
endpackage

// ### src/tout_chan.sv
// One output channel: waveform flip-flop with mode, polarity, enable
`timescale 1ns/1ns
`default_nettype none
module tout_chan
  import tout_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic slave_mode_i,
  input  wire logic pol_i,
  input  wire logic oe_i,
  // Events
  input  wire logic master_irq_i,
  input  wire logic own_irq_i,
  // Software write of the value bit
  input  wire logic sw_we_i,
  input  wire logic sw_val_i,
  // Value bit (pin level)
  output logic      val_o
);
  logic val_ff;
  logic nxt_val;
  logic act;

  always_comb begin
    act = ~pol_i; // RULE4
    nxt_val = val_ff;
    if (oe_i) begin // RULE7
      if (slave_mode_i) begin
        // Reset wins when both events coincide: pulse ends cleanly
        if (own_irq_i) begin
          nxt_val = ~act; // RULE2
        end else if (master_irq_i) begin
          nxt_val = act; // RULE1
        end
      end else if (own_irq_i) begin
        nxt_val = ~val_ff; // RULE3
      end
    end else if (sw_we_i) begin
      nxt_val = sw_val_i; // RULE8
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      val_ff <= 1'b0;
    end else begin
      val_ff <= nxt_val;
    end
  end

  assign val_o = val_ff;
endmodule
`default_nettype wire

// ### bench/timer_output_control_monitor.sv
// Port checker for the timer output control block
`timescale 1ns/1ns
`default_nettype none
module tout_monitor
  import tout_pkg::*;
#(parameter int CHANNELS = NCH)(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o,
  // Timer side
  input wire logic [CHANNELS-1:0] timer_irq_i,
  input wire logic [CHANNELS-1:0] tout_o
);
  // Shadow of enable, polarity, mode; no read-back needed
  logic [11:0] cfg_ff, nxt_cfg;
  logic [3:0]  m, p, e, t, q;
  logic        rq, wr, vwr;
  assign rq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = rq & wb_we_i & wb_sel_i[0] & ~|wb_adr_i[31:5];
  assign vwr = wr & (wb_adr_i[4:2] == IDX_VALUE);
  assign {e, p, m} = cfg_ff;
  assign t = timer_irq_i;
  assign q = tout_o;
  always_comb begin
    nxt_cfg = cfg_ff;
    if (wr && wb_adr_i[4:2] == IDX_MODE) nxt_cfg[3:0] = wb_dat_i[3:0];
    if (wr && wb_adr_i[4:2] == IDX_POL) nxt_cfg[7:4] = wb_dat_i[3:0];
    if (wr && wb_adr_i[4:2] == IDX_OE) nxt_cfg[11:8] = wb_dat_i[3:0];
  end
  always_ff @(posedge clk_i or negedge reset_n_i)
    if (!reset_n_i) cfg_ff <= 12'h0;
    else cfg_ff <= nxt_cfg;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  bus_answer_a:
    assert property (rq |=> wb_ack_o ##1 !wb_ack_o) else $error("bad ack");
  master_toggle_a:
    assert property (e[0] & t[0] |=> q[0] != $past(q[0])) else $error("ch0");
  slave_set_a:
    assert property (e[3] & m[3] & t[0] & ~t[3] |=> q[3] != $past(p[3]))
      else $error("slave set");
  slave_clear_a:
    assert property (e[3] & m[3] & t[3] |=> q[3] == $past(p[3]))
      else $error("slave clear");
  ch3_toggle_a:
    assert property (e[3] & ~m[3] & t[3] |=> q[3] != $past(q[3]))
      else $error("ch3 toggle");
  hold_off_a:
    assert property (~e[3] & ~vwr |=> $stable(q[3])) else $error("ch3 moved");
  sw_value_a:
    assert property (vwr & ~e[3] |=> q[3] == $past(wb_dat_i[3]))
      else $error("ch3 write");
  sw_ch0_a:
    assert property (vwr & ~e[0] |=> q[0] == $past(wb_dat_i[0]))
      else $error("ch0 write");
  cover property (e[3] & m[3] & t[0]);
  cover property (vwr & ~e[0]);
  cover property (e[0] & t[0]);
  cover property (e[3] & m[3] & t[3]);
endmodule
bind timer_output_control tout_monitor #(.CHANNELS(CHANNELS)) u_mon (
  .clk_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .timer_irq_i, .tout_o);
`default_nettype wire

// ### bench/timer_output_control_tb.sv
// Self-checking bench for the timer output control block
`timescale 1ns/1ns
`default_nettype none
module timer_output_control_tb;
  import tout_pkg::*;
  logic        clk_i = '0, reset_n_i = '0, cyc = '0, we = '0, ack;
  logic [31:0] adr = '0, dat = '0, rd, dat_o, s = 32'h5c;
  logic [3:0]  irq = '0, sel = '0, tout, m, p, e, ex = '0;
  logic [11:0] cr [3] = '{12'h908, 12'h988, 12'h000};
  logic [3:0]  ts [3] = '{4'h1, 4'h8, 4'h9};
  logic [26:0] hi = '0;
  int          n_fail = 0, n_tests = 0;
  timer_output_control u_dut (.clk_i, .reset_n_i, .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .timer_irq_i(irq), .tout_o(tout));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  // Channel 0 is the master; slaves 1..3 follow its event
  function automatic logic [3:0] step(input logic [3:0] v, t);
    for (int c = 0; c < 4; c++)
      if (e[c] && t[c]) v[c] = (c > 0 && m[c]) ? p[c] : !v[c];
      else if (e[c] && c > 0 && m[c] && t[0]) v[c] = !p[c];
    return v;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic chk_pin(input string n, input logic [3:0] x, g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic acc(input logic w, input logic [2:0] i,
                     input logic [31:0] d, input logic [3:0] b);
    int k;
    k = 0;
    cyc <= 1'h1;
    we <= w;
    adr <= {hi, i, 2'h0};
    dat <= d;
    sel <= b;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'h1 && k < 50);
    if (ack !== 1'h1) n_fail++;
    rd = dat_o;
    cyc <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rdchk(input string n, input logic [2:0] i,
                       input logic [31:0] x);
    acc(1'h0, i, 32'h0, 4'h3);
    chk(n, x, rd);
  endtask
  task automatic fire(input logic [3:0] t);
    irq <= t;
    @(posedge clk_i);
    irq <= 4'h0;
    ex = step(ex, t);
    @(posedge clk_i);
    chk_pin("tout", ex, tout);
  endtask
  task automatic test_done;
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // Run is under 1500 cycles; ten times that marks a hang
  initial begin
    #150000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      acc(1'h0, i[2:0], 32'h0, 4'h3);
      chk("reset", 32'h0, rd);
    end
    // High address and holes must not land, yet read zero
    hi = 27'h1;
    acc(1'h1, IDX_OE, 32'hf, 4'h3);
    rdchk("unmapped", IDX_OE, 32'h0);
    hi = 27'h0;
    rdchk("oe kept", IDX_OE, 32'h0);
    acc(1'h1, 3'h6, 32'hffff, 4'h3);
    rdchk("hole", 3'h6, 32'h0);
    for (int r = 0; r < 12; r++) begin
      s = xs(s);
      {e, p, m} = r < 3 ? cr[r] : s[11:0];
      acc(1'h1, IDX_MODE, {28'h0, m}, 4'h3);
      acc(1'h1, IDX_POL, {28'h0, p}, 4'h3);
      acc(1'h1, IDX_OE, {28'h0, e}, 4'h3);
      acc(1'h1, IDX_DELAY, s, 4'h3);
      acc(1'h1, IDX_PWIDTH, {s[15:0], s[31:16]}, 4'h3);
      rdchk("delay", IDX_DELAY, {16'h0, s[15:0]});
      rdchk("pwidth", IDX_PWIDTH, {16'h0, s[31:16]});
      rdchk("mode", IDX_MODE, {28'h0, m});
      rdchk("pol", IDX_POL, {28'h0, p});
      rdchk("oe", IDX_OE, {28'h0, e});
      acc(1'h1, IDX_VALUE, {28'h0, s[15:12]}, s[19:16]);
      if (s[16]) ex = (ex & e) | (s[15:12] & ~e);
      chk_pin("written", ex, tout);
      for (int j = 0; j < 6; j++) begin
        s = xs(s);
        fire(j < 3 ? ts[j] : s[3:0]);
      end
      acc(1'h0, IDX_VALUE, 32'h0, 4'h3);
      chk("value", {28'h0, ex}, rd);
    end
    test_done();
  end
endmodule
`default_nettype wire
